// ---- host_ctrl_model.sv ----
// Behavioural host controller that watches the detector's general digital outputs.
// Assumes the outputs are registered on ref_clk and the host samples them on the same clock.
`timescale 1ns/1ps
module host_ctrl_model
	import ipd_pkg::*;
(
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	// Detector outputs and the line that carries in-position.
	input  wire logic [OUT_N-1:0] dout,
	input  wire logic [SEL_W-1:0] sel,
	// What the host has seen.
	output logic                  level,
	output logic      [31:0]      pulses
);
	logic prev_r;

	// Counts rising edges of the selected line; a change of sel can fake one,
	// so pulses are only meaningful while sel is steady.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prev_r <= 1'b0;
			pulses <= 32'h0;
		end
		else
		begin
			prev_r <= dout[sel];
			if (dout[sel] && !prev_r)
			begin
				pulses <= pulses + 32'h1;
			end
		end
	end

	// High on the line means the axis is in position.
	assign level = dout[sel];
endmodule

// ---- in_position_detector.sv ----
// In-position detector: radius compare, debounce, output routing and move timing.
// Assumes position error, operating mode and path-planning busy come from logic on ref_clk.
//
// Overview of operation
// - In-position rises once the error has stayed inside the radius over as many microsecond ticks as the debounce time.
// - The check runs only in position or stand-alone mode; otherwise the status stays low.
// - The selected output is high while in-position is achieved and low while it is not.
// - After reset the status goes to the second general output; the choice can be changed.
// - The target radius resets to one hundred times the encoder resolution.
// - A zero debounce time makes the status follow the raw comparison, pulses and all.
// - Move time, settling time and their sum as total time are reported separately.
`timescale 1ns/1ps
module in_position_detector
	import ipd_pkg::*;
(
	// Clock and reset.
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// Register port.
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// Servo loop state.
	input  wire logic [ERR_W-1:0]  pos_err,
	input  wire op_mode_t          op_mode,
	input  wire logic              path_busy,
	// Status outputs.
	output logic                   in_pos,
	output logic      [OUT_N-1:0]  general_out
);

	// Microsecond tick.
	logic [US_CNT_W-1:0] us_cnt_r;
	logic [US_CNT_W-1:0] us_cnt_nxt;
	logic                tick_r;
	logic                tick_nxt;

	always_comb
	begin
		tick_nxt   = 1'b0;
		us_cnt_nxt = us_cnt_r + 7'h01;
		if (us_cnt_r == US_CNT_W'(US_CYCLES - 1))
		begin
			us_cnt_nxt = '0;
			tick_nxt   = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			us_cnt_r <= '0;
			tick_r   <= 1'b0;
		end
		else
		begin
			us_cnt_r <= us_cnt_nxt;
			tick_r   <= tick_nxt;
		end
	end

	// Configuration registers.
	logic [SEL_W-1:0]  out_sel_r;
	logic [SEL_W-1:0]  out_sel_nxt;
	logic [DATA_W-1:0] radius_r;
	logic [DATA_W-1:0] radius_nxt;
	logic [DEB_W-1:0]  debounce_r;
	logic [DEB_W-1:0]  debounce_nxt;

	always_comb
	begin
		out_sel_nxt  = out_sel_r;
		radius_nxt   = radius_r;
		debounce_nxt = debounce_r;
		if (reg_wr)
		begin
			if (reg_addr == OFS_CTRL)
				out_sel_nxt = reg_wdata[SEL_W-1:0];
			else if (reg_addr == OFS_RADIUS)
				radius_nxt = reg_wdata;
			else if (reg_addr == OFS_DEBOUNCE)
				debounce_nxt = reg_wdata[DEB_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			out_sel_r  <= OUT_SEL_RST;
			radius_r   <= RADIUS_RST;
			debounce_r <= DEBOUNCE_RST;
		end
		else
		begin
			out_sel_r  <= out_sel_nxt;
			radius_r   <= radius_nxt;
			debounce_r <= debounce_nxt;
		end
	end

	// Radius compare. The magnitude is one bit wider so the most negative error
	// cannot wrap round to a small value and fake an entry.
	logic              in_radius_r;
	logic              in_radius_nxt;
	logic              mode_ok_r;
	logic              mode_ok_nxt;
	logic [ERR_W:0]    err_mag;

	always_comb
	begin
		err_mag = {pos_err[ERR_W-1], pos_err};
		if (pos_err[ERR_W-1])
		begin
			err_mag = (ERR_W+1)'(0) - {pos_err[ERR_W-1], pos_err};
		end
		in_radius_nxt = (err_mag <= {1'b0, radius_r});
		mode_ok_nxt   = (op_mode == MODE_POSITION) ||
		                (op_mode == MODE_STANDALONE);
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			in_radius_r <= 1'b0;
			mode_ok_r   <= 1'b0;
		end
		else
		begin
			in_radius_r <= in_radius_nxt;
			mode_ok_r   <= mode_ok_nxt;
		end
	end

	// Debounce.
	settle_debounce u_debounce (
		.ref_clk     (ref_clk),
		.arst_n      (arst_n),
		.tick        (tick_r),
		.qualify     (mode_ok_r && in_radius_r),
		.debounce_us (debounce_r),
		.in_pos      (in_pos)
	);

	// Output routing, one flop per general output.
	logic [OUT_N-1:0] gen_out_r;

	generate
		for (genvar i = 0; i < OUT_N; i++)
		begin : g_out
			logic out_nxt;

			always_comb
			begin
				out_nxt = in_pos && (out_sel_r == SEL_W'(i));
			end

			always_ff @(posedge ref_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					gen_out_r[i] <= 1'b0;
				end
				else
				begin
					gen_out_r[i] <= out_nxt;
				end
			end
		end
	endgenerate

	assign general_out = gen_out_r;

	// Move and settling timing, counted in microseconds.
	time_state_t       tstate_r;
	time_state_t       tstate_nxt;
	logic [DATA_W-1:0] move_r;
	logic [DATA_W-1:0] move_nxt;
	logic [DATA_W-1:0] settle_r;
	logic [DATA_W-1:0] settle_nxt;
	logic [DATA_W-1:0] total_r;
	logic [DATA_W-1:0] total_nxt;

	always_comb
	begin
		tstate_nxt = tstate_r;
		move_nxt   = move_r;
		settle_nxt = settle_r;
		case (tstate_r)
			T_IDLE:
			begin
				if (path_busy)
				begin
					tstate_nxt = T_MOVE;
					move_nxt   = '0;
					settle_nxt = '0;
				end
			end
			T_MOVE:
			begin
				if (tick_r)
					move_nxt = move_r + 32'h00000001;
				if (!path_busy)
					tstate_nxt = T_SETTLE;
			end
			T_SETTLE:
			begin
				if (path_busy)
				begin
					// A new move before settling restarts the measurement.
					tstate_nxt = T_MOVE;
					move_nxt   = '0;
					settle_nxt = '0;
				end
				else if (in_pos)
					tstate_nxt = T_IDLE;
				else if (tick_r)
					settle_nxt = settle_r + 32'h00000001;
			end
			default:
				tstate_nxt = T_IDLE;
		endcase
		total_nxt = move_nxt + settle_nxt;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tstate_r <= T_IDLE;
			move_r   <= '0;
			settle_r <= '0;
			total_r  <= '0;
		end
		else
		begin
			tstate_r <= tstate_nxt;
			move_r   <= move_nxt;
			settle_r <= settle_nxt;
			total_r  <= total_nxt;
		end
	end

	// Read port: data stand for one cycle after the strobe, zero otherwise.
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;

	always_comb
	begin
		rdata_nxt = '0;
		if (reg_rd)
		begin
			if (reg_addr == OFS_CTRL)
				rdata_nxt[SEL_W-1:0] = out_sel_r;
			else if (reg_addr == OFS_RADIUS)
				rdata_nxt = radius_r;
			else if (reg_addr == OFS_DEBOUNCE)
				rdata_nxt[DEB_W-1:0] = debounce_r;
			else if (reg_addr == OFS_STATUS)
			begin
				rdata_nxt[ST_INPOS_BIT]  = in_pos;
				rdata_nxt[ST_RADIUS_BIT] = in_radius_r;
				rdata_nxt[ST_MODE_BIT]   = mode_ok_r;
				rdata_nxt[ST_STATE_LSB +: 2] = tstate_r;
			end
			else if (reg_addr == OFS_MOVE)
				rdata_nxt = move_r;
			else if (reg_addr == OFS_SETTLE)
				rdata_nxt = settle_r;
			else if (reg_addr == OFS_TOTAL)
				rdata_nxt = total_r;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata_r <= '0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	sequence s_mode_bad;
		!mode_ok_nxt ##1 !mode_ok_r;
	endsequence

	a_mode_gate: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		s_mode_bad |=> !in_pos)
		else $error("in-position high outside position or stand-alone mode");

	a_out_level: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		$stable(out_sel_r) |-> (general_out[out_sel_r] == $past(in_pos)))
		else $error("selected output does not follow in-position");

	a_reset_select: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		$rose(arst_n) |-> (out_sel_r == OUT_SEL_RST))
		else $error("output select wrong after reset");

	a_reset_radius: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		$rose(arst_n) |-> (radius_r == RADIUS_RST))
		else $error("target radius wrong after reset");

	a_total_sum: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		total_r == (move_r + settle_r))
		else $error("total time differs from move plus settling time");

	a_move_count: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(tstate_r == T_MOVE && tick_r) |=> (move_r == $past(move_r) + 32'h00000001))
		else $error("move time did not advance during the move");

endmodule

// ---- ipd_pkg.sv ----
// Constants, register map and types shared by the in-position detector files.
// Assumes a single 100 MHz clock; all times are counted in microsecond ticks.
package ipd_pkg;

	// Widths.
	localparam int ERR_W  = 32;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int DEB_W  = 16;
	localparam int OUT_N  = 4;
	localparam int SEL_W  = 2;

	// Time base: the clock period and one microsecond, both in picoseconds.
	localparam int CLK_PERIOD_PS = 10000;
	localparam int US_PS         = 1000000;
	localparam int US_CYCLES     = US_PS / CLK_PERIOD_PS;
	localparam int US_CNT_W      = 7;

	// Target radius after reset is a multiple of the encoder resolution.
	localparam int ENC_RES_COUNTS = 1;
	localparam int RADIUS_FACTOR  = 100;

	// Values after reset.
	localparam logic [DATA_W-1:0] RADIUS_RST   = DATA_W'(RADIUS_FACTOR * ENC_RES_COUNTS);
	localparam logic [DEB_W-1:0]  DEBOUNCE_RST = 16'h0000;
	localparam logic [SEL_W-1:0]  OUT_SEL_RST  = 2'h1;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RADIUS   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DEBOUNCE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_MOVE     = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_SETTLE   = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_TOTAL    = 8'h18;

	// Status field positions.
	localparam int ST_INPOS_BIT  = 0;
	localparam int ST_RADIUS_BIT = 1;
	localparam int ST_MODE_BIT   = 2;
	localparam int ST_STATE_LSB  = 4;

	typedef enum logic [2:0] {
		MODE_POSITION   = 3'b000,
		MODE_STANDALONE = 3'b001,
		MODE_VELOCITY   = 3'b010,
		MODE_TORQUE     = 3'b011,
		MODE_OTHER      = 3'b100
	} op_mode_t;

	typedef enum logic [1:0] {
		T_IDLE   = 2'b00,
		T_MOVE   = 2'b01,
		T_SETTLE = 2'b10
	} time_state_t;

endpackage

// ---- settle_debounce.sv ----
// Debounce counter that turns a qualified in-radius level into the in-position level.
// Assumes the qualify level and the microsecond tick come from flops on ref_clk.
`timescale 1ns/1ps
module settle_debounce
	import ipd_pkg::*;
(
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	// Time base and condition.
	input  wire logic             tick,
	input  wire logic             qualify,
	input  wire logic [DEB_W-1:0] debounce_us,
	// Result.
	output logic                  in_pos
);

	logic [DEB_W-1:0] cnt_r;
	logic [DEB_W-1:0] cnt_nxt;
	logic             inpos_r;
	logic             inpos_nxt;

	always_comb
	begin
		cnt_nxt   = cnt_r;
		inpos_nxt = inpos_r;
		if (!qualify)
		begin
			// Any exit from the radius restarts the wait and drops the status.
			cnt_nxt   = '0;
			inpos_nxt = 1'b0;
		end
		else if (debounce_us == '0)
		begin
			// No debounce: every short entry shows up as a pulse.
			cnt_nxt   = '0;
			inpos_nxt = 1'b1;
		end
		else
		begin
			if (tick && (cnt_r < debounce_us))
			begin
				cnt_nxt = cnt_r + 16'h0001;
			end
			inpos_nxt = inpos_r || (cnt_nxt >= debounce_us);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_r   <= '0;
			inpos_r <= 1'b0;
		end
		else
		begin
			cnt_r   <= cnt_nxt;
			inpos_r <= inpos_nxt;
		end
	end

	assign in_pos = inpos_r;

	// Cycles the condition has held without a break, for checking only.
	logic [31:0] hold_cyc_r;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hold_cyc_r <= '0;
		end
		else if (!qualify)
		begin
			hold_cyc_r <= '0;
		end
		else if (hold_cyc_r != 32'hFFFFFFFF)
		begin
			hold_cyc_r <= hold_cyc_r + 32'h00000001;
		end
	end

	a_drop_outside: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!qualify |=> !in_pos)
		else $error("in-position stayed high outside the radius");

	a_raw_follow: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(qualify && (debounce_us == '0)) |=> in_pos)
		else $error("zero debounce did not follow the raw comparison");

	a_hold_before_set: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		($rose(in_pos) && $stable(debounce_us) && (debounce_us != '0))
		|-> (32'(hold_cyc_r) >= 32'((32'(debounce_us) - 32'd1) * 32'(US_CYCLES))))
		else $error("in-position rose before the debounce interval");

endmodule

// ---- testbench.sv ----
// Self-checking bench for the in-position detector, driving its register and servo ports.
// Assumes a 100 MHz ref_clk and that one microsecond tick is 100 cycles.
`timescale 1ns/1ps
module testbench
	import ipd_pkg::*;
;
	logic              ref_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 32'h0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [ERR_W-1:0]  pos_err = 32'h3E8;
	op_mode_t          op_mode = MODE_POSITION;
	logic              path_busy = 1'b0;
	logic              in_pos;
	logic [OUT_N-1:0]  general_out;
	logic [SEL_W-1:0]  out_sel = 2'h1;
	logic              host_level;
	logic [31:0]       host_pulses;
	int                n_mismatch = 0;
	int                comparisons = 0;
	localparam logic [ERR_W-1:0] FAR = 32'h3E8;
	op_mode_t          bad_modes[3] = '{MODE_VELOCITY, MODE_TORQUE, MODE_OTHER};
	logic [ERR_W-1:0]  edge_err[4] = '{32'h64, 32'h65, 32'hFFFFFF9C, 32'hFFFFFF9B};
	logic              edge_exp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	in_position_detector uut (
		.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_err(pos_err),
		.op_mode(op_mode), .path_busy(path_busy), .in_pos(in_pos), .general_out(general_out)
	);

	host_ctrl_model host (
		.ref_clk(ref_clk), .arst_n(arst_n), .dout(general_out), .sel(out_sel),
		.level(host_level), .pulses(host_pulses)
	);

	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_range(input string name, input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] got);
		comparisons++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			n_mismatch++;
			$display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] e);
		logic [DATA_W-1:0] v;
		rd(a, v);
		chk_word(name, e, v);
	endtask

	task automatic set_in(input logic [ERR_W-1:0] e, input op_mode_t m);
		@(posedge ref_clk);
		pos_err <= e;
		op_mode <= m;
	endtask

	// Waits for in-position under a bound and returns the edges it took.
	task automatic wait_hi(input int maxc, output int n);
		n = 0;
		while (in_pos !== 1'b1 && n < maxc)
		begin
			cyc(1);
			n++;
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#300000;
		n_mismatch++;
		wrap_up();
	end

	initial
	begin
		int n;
		logic [31:0] p0;
		logic [DATA_W-1:0] mv;
		logic [DATA_W-1:0] st;
		logic [DATA_W-1:0] tot;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		cyc(1);
		chk_bit("in_pos reset", 1'b0, in_pos);
		chk_word("outputs reset", 32'h0, {28'h0, general_out});
		rd_chk("ctrl reset", OFS_CTRL, {30'h0, OUT_SEL_RST});
		rd_chk("radius reset", OFS_RADIUS, RADIUS_RST);
		rd_chk("debounce reset", OFS_DEBOUNCE, {16'h0, DEBOUNCE_RST});
		rd_chk("total reset", OFS_TOTAL, 32'h0);
		rd_chk("unmapped", 8'h1C, 32'h0);
		$display("test reset done");
		foreach (edge_err[i])
		begin
			set_in(edge_err[i], MODE_POSITION);
			cyc(2);
			chk_bit("radius edge", edge_exp[i], in_pos);
		end
		$display("test radius done");
		p0 = host_pulses;
		for (int k = 0; k < 2; k++)
		begin
			set_in(32'h0, MODE_POSITION);
			set_in(FAR, MODE_POSITION);
			cyc(4);
		end
		chk_word("pulses", p0 + 32'h2, host_pulses);
		$display("test pulses done");
		foreach (bad_modes[i])
		begin
			set_in(32'h0, bad_modes[i]);
			cyc(3);
			chk_bit("mode in_pos", 1'b0, in_pos);
			chk_word("mode outputs", 32'h0, {28'h0, general_out});
		end
		set_in(32'h0, MODE_STANDALONE);
		cyc(2);
		chk_bit("standalone", 1'b1, in_pos);
		cyc(1);
		chk_word("second output", 32'h2, {28'h0, general_out});
		chk_bit("host level", 1'b1, host_level);
		$display("test modes done");
		// The tick phase is free running, so N ticks take between (N-1)*100+2
		// and N*100+1 edges after the error moves; the checks sit at the bounds.
		set_in(FAR, MODE_POSITION);
		wr(OFS_DEBOUNCE, 32'h2);
		set_in(32'h0, MODE_POSITION);
		cyc(101);
		chk_bit("debounce early", 1'b0, in_pos);
		wait_hi(101, n);
		chk_range("debounce rise", 1, 100, n);
		chk_bit("debounce high", 1'b1, in_pos);
		set_in(FAR, MODE_POSITION);
		wr(OFS_DEBOUNCE, 32'h3);
		cyc(3);
		set_in(32'h0, MODE_POSITION);
		cyc(150);
		set_in(FAR, MODE_POSITION);
		set_in(32'h0, MODE_POSITION);
		cyc(201);
		chk_bit("restart early", 1'b0, in_pos);
		wait_hi(101, n);
		chk_bit("restart high", 1'b1, in_pos);
		set_in(FAR, MODE_POSITION);
		cyc(2);
		chk_bit("leave drop", 1'b0, in_pos);
		$display("test debounce done");
		wr(OFS_CTRL, 32'h3);
		out_sel <= 2'h3;
		wr(OFS_DEBOUNCE, 32'h0);
		set_in(32'h0, MODE_POSITION);
		cyc(3);
		chk_word("fourth output", 32'h8, {28'h0, general_out});
		rd_chk("ctrl moved", OFS_CTRL, 32'h3);
		$display("test select done");
		set_in(FAR, MODE_POSITION);
		path_busy <= 1'b1;
		repeat (500) @(posedge ref_clk);
		path_busy <= 1'b0;
		cyc(300);
		set_in(32'h0, MODE_POSITION);
		cyc(5);
		rd(OFS_MOVE, mv);
		rd(OFS_SETTLE, st);
		rd(OFS_TOTAL, tot);
		chk_range("move time", 4, 6, mv);
		chk_range("settle time", 2, 4, st);
		chk_word("total time", mv + st, tot);
		rd_chk("status", OFS_STATUS, 32'h7);
		$display("test timing done");
		wrap_up();
	end
endmodule
